// >>> verilog/lsf_pkg.sv
// Package for the LED sink fault-status logic: sizes, modes and carriers
// How it works
// [R1] A 16-bit shift register and output latch drive sixteen sink channels.
// [R2] Open-load status reads 1 only when channel on and current meets threshold.
// [R3] Optional short detect: bit drops at trip, returns only below release level.
// [R4] Global overtemperature turns every channel off and zeroes every status bit.
// [R5] A channel overtemperature turns off and zeroes only that channel.
// [R6] Cooled channels restart by themselves if their latch bit is still on.
// [R7] An overtemperature zero stays stored after cooling until cleared.
// [R8] Entering normal mode clears all per-channel error status bits; code clears trip_mem_reg only, not short_ok_reg.
// [R9] Channel overtemperature counts only while that channel is on.
// [R10] Enable pattern 101 starts switching; latch level at fourth edge picks mode.
// [R11] Special mode, enable low: second low selects status, third captures it.
// [R12] After reset the block is in normal mode with status cleared.
// [R13] Normal mode: latch strobe high loads outputs; enable low lets sinks run.
// [R14] Each status bit loads into the shift position of its channel data bit.
// [R15] Short detection is a build option; off leaves open-load and overheat only.
package lsf_pkg;
  localparam int          LSF_CH       = 16;
  localparam logic [15:0] LSF_ZERO16   = 16'h0000;
  localparam logic [1:0]  LSF_CNT_MAX  = 2'h3;
  localparam logic [1:0]  LSF_SW_EDGES = 2'h2;
  localparam logic [1:0]  LSF_LOW_SEL  = 2'h2;
  localparam logic [1:0]  LSF_LOW_CAP  = 2'h3;

  typedef enum logic [1:0] {LSF_NORMAL, LSF_SWITCH, LSF_SPECIAL} lsf_mode_e;

  typedef struct packed {
    logic [15:0] cur_ok;
    logic [15:0] v_trip;
    logic [15:0] v_release;
    logic [15:0] ot_chan;
    logic        ot_glob;
  } lsf_sense_s;
endpackage

// >>> verilog/lsf_led_sink.sv
// Fault-status and channel control logic of the sixteen-channel sink driver
`timescale 1ns/1ps
module lsf_led_sink
  import lsf_pkg::*;
#(
  parameter bit SHORT_DET = 1'b1
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_serial_in,
  input  wire logic        i_latch_strobe_mode_select,
  input  wire logic        i_output_enable_detect_strobe_n,
  input  wire lsf_sense_s  i_sense,
  output logic             o_serial_out,
  output logic [15:0]      o_sink_channel,
  output logic             o_special_mode
);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [2:0]  pin_s1_reg, pin_s2_reg;
  lsf_sense_s  sen_s1_reg, sen_s2_reg;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Idle pin levels, so the pulse detector sees no edge after reset
      pin_s1_reg <= 3'h4;
      pin_s2_reg <= 3'h4;
      sen_s1_reg <= '0;
      sen_s2_reg <= '0;
    end else begin
      pin_s1_reg <= {i_output_enable_detect_strobe_n,
                     i_latch_strobe_mode_select, i_serial_in};
      pin_s2_reg <= pin_s1_reg;
      sen_s1_reg <= i_sense;
      sen_s2_reg <= sen_s1_reg;
    end
  end
  logic serial_in, le, oe_n;
  assign serial_in  = pin_s2_reg[0];
  assign le   = pin_s2_reg[1];
  assign oe_n = pin_s2_reg[2];

  // ------------------------------------------------------------------
  // Mode switching
  // ------------------------------------------------------------------
  logic [1:0] oe_hist_reg;
  lsf_mode_e  mode_reg;
  logic [1:0] sw_cnt_reg;
  logic       pulse_seen;
  assign pulse_seen = oe_n && !oe_hist_reg[0] && oe_hist_reg[1];
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_hist_reg <= 2'h3;
      mode_reg    <= LSF_NORMAL; // R12
      sw_cnt_reg  <= 2'h0;
    end else begin
      oe_hist_reg <= {oe_hist_reg[0], oe_n};
      if (pulse_seen && mode_reg != LSF_SWITCH) begin
        mode_reg   <= LSF_SWITCH; // R10
        sw_cnt_reg <= 2'h0;
      end else if (mode_reg == LSF_SWITCH) begin
        sw_cnt_reg <= sw_cnt_reg + 2'h1;
        // Pattern ends at edge 3; the next edge is the fourth
        if (sw_cnt_reg == 2'h0)
          mode_reg <= le ? LSF_SPECIAL : LSF_NORMAL; // R10
      end
    end
  end
  logic to_normal;
  assign to_normal = mode_reg == LSF_SWITCH && sw_cnt_reg == 2'h0 && !le;

  // ------------------------------------------------------------------
  // Detect-low counter
  // ------------------------------------------------------------------
  logic [1:0] low_cnt_reg;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      low_cnt_reg <= 2'h0;
    else if (oe_n || mode_reg != LSF_SPECIAL)
      low_cnt_reg <= 2'h0;
    else if (low_cnt_reg != LSF_CNT_MAX)
      low_cnt_reg <= low_cnt_reg + 2'h1;
  end
  logic capture;
  // Count already holds two lows, so this edge is the third or later
  assign capture = mode_reg == LSF_SPECIAL && !oe_n
                   && low_cnt_reg >= LSF_LOW_SEL; // R11

  // ------------------------------------------------------------------
  // Shift register and output latch
  // ------------------------------------------------------------------
  logic [15:0] shift_reg, latch_reg, status_reg, trip_mem_reg;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      shift_reg <= LSF_ZERO16;
    else if (capture)
      shift_reg <= status_reg; // R11 R14
    else if (!(mode_reg == LSF_SPECIAL && !oe_n))
      shift_reg <= {shift_reg[14:0], serial_in}; // R1
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_reg <= LSF_ZERO16;
    end else if (le && mode_reg == LSF_NORMAL) begin
      latch_reg <= shift_reg; // R13
    end
    // Strobe outside normal mode would feed the gain code, which has no
    // analog stage behind it here, so it is not stored at all
  end

  // ------------------------------------------------------------------
  // Per-channel status and drive
  // ------------------------------------------------------------------
  logic [15:0] short_ok_reg, drive;
  genvar g;
  generate
    for (g = 0; g < LSF_CH; g++) begin : g_ch
      logic on_cmd, hot;
      assign on_cmd = latch_reg[g] && !oe_n;
      assign hot    = sen_s2_reg.ot_glob || (on_cmd && sen_s2_reg.ot_chan[g]); // R4 R5 R9
      assign drive[g] = on_cmd && !hot; // R6
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          short_ok_reg[g] <= 1'b1;
          trip_mem_reg[g] <= 1'b0;
        end else begin
          if (sen_s2_reg.v_trip[g])
            short_ok_reg[g] <= 1'b0; // R3
          else if (sen_s2_reg.v_release[g])
            short_ok_reg[g] <= 1'b1; // R3
          if (hot)
            trip_mem_reg[g] <= 1'b1; // R7
          else if (to_normal)
            trip_mem_reg[g] <= 1'b0; // R8
        end
      end
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n)
          status_reg[g] <= 1'b0; // R12
        else
          status_reg[g] <= drive[g] && sen_s2_reg.cur_ok[g] // R2
                           && (!SHORT_DET || short_ok_reg[g]) // R15
                           && !trip_mem_reg[g] && !hot; // R4 R5 R7
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sink_channel <= LSF_ZERO16;
      o_serial_out   <= 1'b0;
      o_special_mode <= 1'b0;
    end else begin
      o_sink_channel <= drive; // R13
      o_serial_out   <= shift_reg[15];
      o_special_mode <= mode_reg == LSF_SPECIAL;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_global_off: assert property ( // R4
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    sen_s2_reg.ot_glob |=> o_sink_channel == LSF_ZERO16)
    else $error("channel on during global overtemperature");
  a_glob_status: assert property ( // R4
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    sen_s2_reg.ot_glob |=> status_reg == LSF_ZERO16)
    else $error("status not zero after global overtemperature");
  a_chan_off: assert property ( // R5
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    sen_s2_reg.ot_chan[0] && latch_reg[0] && !oe_n |=> !o_sink_channel[0])
    else $error("channel 0 stayed on while hot");
  a_resume: assert property ( // R6
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    latch_reg[0] && !oe_n && !sen_s2_reg.ot_glob && !sen_s2_reg.ot_chan[0]
    |=> o_sink_channel[0])
    else $error("channel 0 did not resume");
  a_trip_held: assert property ( // R7
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    trip_mem_reg[0] && !to_normal |=> trip_mem_reg[0] && !status_reg[0])
    else $error("trip memory lost");
  a_normal_clr: assert property ( // R8
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    to_normal && !sen_s2_reg.ot_glob && sen_s2_reg.ot_chan == LSF_ZERO16
    |=> trip_mem_reg == LSF_ZERO16)
    else $error("errors not cleared on normal entry");
  a_mode_pick: assert property ( // R10
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    mode_reg == LSF_SWITCH && sw_cnt_reg == 2'h0
    |=> mode_reg == ($past(le) ? LSF_SPECIAL : LSF_NORMAL))
    else $error("wrong mode after switching");
  a_pulse_enter: assert property ( // R10
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    pulse_seen && mode_reg != LSF_SWITCH |=> mode_reg == LSF_SWITCH)
    else $error("enable pulse did not start switching");
  a_capture: assert property ( // R11
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    capture |=> shift_reg == $past(status_reg))
    else $error("status not captured");
  a_shift_hold: assert property ( // R11
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    mode_reg == LSF_SPECIAL && !oe_n && !capture
    |=> shift_reg == $past(shift_reg))
    else $error("serial data shifted during detection");
  a_latch_load: assert property ( // R13
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    le && mode_reg == LSF_NORMAL |=> latch_reg == $past(shift_reg))
    else $error("output latch not loaded");
  a_latch_keep: assert property ( // R13
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    mode_reg != LSF_NORMAL |=> latch_reg == $past(latch_reg))
    else $error("output latch loaded outside normal mode");
  a_status_ok: assert property ( // R2
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    drive[0] && sen_s2_reg.cur_ok[0] && short_ok_reg[0]
    && !trip_mem_reg[0] |=> status_reg[0])
    else $error("status low on a healthy channel");
  a_short_stat: assert property ( // R3
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    SHORT_DET && !short_ok_reg[0] |=> !status_reg[0])
    else $error("shorted channel reported healthy");
  a_off_zero: assert property ( // R2
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    oe_n || !latch_reg[0] |=> !status_reg[0])
    else $error("status high on an off channel");
  c_special: cover property (@(posedge i_sys_clk) mode_reg == LSF_SPECIAL);
  c_capture: cover property (@(posedge i_sys_clk) capture);
  c_glob: cover property (@(posedge i_sys_clk) sen_s2_reg.ot_glob);
  c_to_normal: cover property (@(posedge i_sys_clk) to_normal);
  c_short: cover property (@(posedge i_sys_clk) !short_ok_reg[0]);
endmodule

// >>> test/lsf_ctrl.sv
// Controller model: serial data, latch strobe and enable strobe
`timescale 1ns/1ps
module lsf_ctrl (
  input  wire logic i_sys_clk,
  output logic      o_serial_in,
  output logic      o_latch,
  output logic      o_oe_n
);
  initial begin
    o_serial_in = 1'b0;
    o_latch = 1'b0;
    o_oe_n = 1'b1;
  end
  // Pins change just after the edge, as the real controller would
  task automatic tick();
    @(posedge i_sys_clk) #1;
  endtask
  task automatic en(input logic v);
    tick();
    o_oe_n = v;
  endtask
  // First bit sent ends at the top of the word
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      tick();
      o_serial_in = w[i];
    end
    tick();
    o_latch = 1'b1;
    tick();
    o_latch = 1'b0;
  endtask
  task automatic mode(input logic sel);
    en(1'b1);
    en(1'b0);
    en(1'b1);
    tick();
    o_latch = sel;
    tick();
    o_latch = 1'b0;
  endtask
endmodule

// >>> test/lsf_led_sink_test.sv
// Self-checking bench for the sink fault-status logic
`timescale 1ns/1ps
module lsf_led_sink_test;
  import lsf_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  lsf_sense_s  sense = '0;
  logic        serial_in, le, oe_n, serial_out, spec;
  logic [15:0] sink, w, c, h, t;
  int          num_errors = 0;
  int          total_checks = 0;
  always #2.5 clk = ~clk;
  lsf_ctrl ctl_u (.i_sys_clk(clk), .o_serial_in(serial_in), .o_latch(le),
    .o_oe_n(oe_n));
  lsf_led_sink dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_serial_in(serial_in),
    .i_latch_strobe_mode_select(le), .i_output_enable_detect_strobe_n(oe_n),
    .i_sense(sense), .o_serial_out(serial_out), .o_sink_channel(sink),
    .o_special_mode(spec));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] stat(logic [15:0] on, ok, hot);
    return on & ok & ~hot;
  endfunction
  task automatic tick();
    @(posedge clk) #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Status word leaves serial out two samples after the strobe goes high
  task automatic det(input logic [15:0] es, input logic [15:0] ex);
    logic [27:0] hist;
    hist = '0;
    ctl_u.en(1'b0);
    repeat (8) tick();
    check(sink, es);
    ctl_u.en(1'b1);
    repeat (28) begin
      tick();
      hist = {hist[26:0], serial_out};
    end
    check(hist[25:10], ex);
  endtask
  initial begin
    void'($urandom(76));
    fork
      begin
        #20000;
        num_errors++;
        results();
      end
    join_none
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    check(sink, 16'h0000);
    check({15'h0000, spec}, 16'h0000);
    for (int it = 0; it < 3; it++) begin
      w = (it == 0) ? 16'hffff : 16'($urandom);
      c = (it == 0) ? 16'hffff : 16'($urandom);
      h = (it == 0) ? 16'h8001 : 16'($urandom);
      t = (it == 0) ? 16'h4001 : 16'($urandom);
      ctl_u.send(w);
      ctl_u.en(1'b0);
      repeat (6) tick();
      check(sink, w);
      ctl_u.mode(1'b1);
      repeat (4) tick();
      check({15'h0000, spec}, 16'h0001);
      sense.cur_ok = c;
      sense.ot_chan = h;
      repeat (6) tick();
      sense.ot_chan = '0;
      det(w, stat(w, c, 16'h0000));
      sense.ot_chan = h;
      det(w & ~h, stat(w, c, h));
      sense.ot_chan = '0;
      det(w, stat(w, c, h));
      sense.ot_glob = 1'b1;
      det(16'h0000, 16'h0000);
      sense.ot_glob = 1'b0;
      det(w, 16'h0000);
      ctl_u.mode(1'b0);
      repeat (4) tick();
      check({15'h0000, spec}, 16'h0000);
      ctl_u.mode(1'b1);
      det(w, stat(w, c, 16'h0000));
      sense.v_trip = t;
      det(w, stat(w, c, t));
      sense.v_trip = '0;
      det(w, stat(w, c, t));
      sense.v_release = 16'hffff;
      det(w, stat(w, c, 16'h0000));
      sense.v_release = '0;
      ctl_u.mode(1'b0);
      $display("iteration %0d done", it);
    end
    // Reset in mid-run, from special mode with channels sinking
    ctl_u.mode(1'b1);
    ctl_u.en(1'b0);
    repeat (6) tick();
    check(sink, w);
    check({15'h0000, spec}, 16'h0001);
    rst_n = 1'b0;
    tick();
    check(sink, 16'h0000);
    rst_n = 1'b1;
    repeat (6) tick();
    check(sink, 16'h0000);
    check({15'h0000, spec}, 16'h0000);
    ctl_u.en(1'b1);
    $display("reset test done");
    results();
  end
endmodule
